// file: dv/mrc_checker_sva.sv
// Assertions on the register port and device pins
`timescale 1ns/1ps
`default_nettype none
module mrc_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] rdata,
  input wire logic reset_strobe_pin,
  input wire logic strobe_in,
  input wire logic highway_clock_enable,
  input wire logic [3:0] upstream_indication,
  input wire logic addressing_select,
  input wire logic reference_disable,
  input wire logic upstream_data_low,
  input wire logic [5:0] block_reset,
  input wire logic [3:0] downstream_command_channel
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence latch_taken;
    cs && wr && !addr[0] && !addressing_select;
  endsequence
  sequence no_read;
    !(cs && rd);
  endsequence
  // Strobe mode copies strobe_in, so a rise with strobe_in low is a reset pulse
  sequence pulse_start;
    $rose(reset_strobe_pin) && !strobe_in;
  endsequence
  // Sleep notice arrives with no wake bit and no write that could force awake
  sequence sleep_notice_seen;
    $changed(downstream_command_channel) && !upstream_data_low && !(cs && wr)
      && downstream_command_channel == mrc_pkg::mrc_sleep_notice_cmd;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_hw_reset_pin: assert property (disable iff (1'b0) rst |-> reset_strobe_pin)
    else $error("reset pin low during reset");
  chk_indirect_pair: assert property (latch_taken |=> cs && addr[0] && (rd || wr))
    else $error("address latch not followed by data access");
  chk_rdata_idle: assert property (no_read ##1 1 |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_pulse_hold: assert property (pulse_start |-> reset_strobe_pin [*8])
    else $error("reset pulse too short");
  chk_state_codes: assert property (
    upstream_indication == mrc_pkg::mrc_sleep_state_code
    || upstream_indication == mrc_pkg::mrc_awake_state_code)
    else $error("unknown state code");
  chk_sleep_notice: assert property (sleep_notice_seen |=>
    upstream_indication == mrc_pkg::mrc_sleep_state_code)
    else $error("sleep notice did not reach sleep");
  chk_awake_clock: assert property (
    upstream_indication == mrc_pkg::mrc_awake_state_code |-> highway_clock_enable)
    else $error("clocks stopped while awake");
  chk_soft_reset_write: assert property ($changed(block_reset) |-> $past(cs && wr))
    else $error("block reset moved without a write");
  chk_options_write: assert property (!$past(cs && wr)
    |-> $stable({reference_disable, addressing_select}))
    else $error("options moved without a write");
  chk_wake_write: assert property ($changed(upstream_data_low) |-> $past(cs && wr))
    else $error("wake line moved without a write");
endmodule : mrc_checker
`default_nettype wire

// file: dv/tb_mode_reset_control.sv
// Testbench joining host and device ends across the register port
`timescale 1ns/1ps
`default_nettype none
module tb_mode_reset_control;
  localparam int pulse = 20;
  localparam logic [5:0] dnum = 6'h15; // Arbitrary value
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, direct_mode = 1'b0;
  logic [7:0] req_addr = 8'h00, req_wdata = 8'h00;
  logic wake = 1'b0, sd = 1'b0, stb = 1'b0;
  logic [3:0] cmd = 4'h0;
  logic req_ready, resp_valid, la, hce, udl, pin, oe_n, rdis, addr_sel, sdo;
  logic [7:0] resp_data;
  logic [3:0] ind;
  logic [5:0] blk;
  logic [7:0] expq[$];
  int failures = 0;
  int checks_done = 0;
  mrc_if bus ();
  mrc_host u_mrc_host (.clock(clock), .rst(rst), .bus(bus.host), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .direct_mode(direct_mode), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_data(resp_data));
  mrc_device #(.design_number(dnum), .pulse_cycles(pulse), .wdog_cycles(200)) u_mrc_device (
    .clock(clock), .rst(rst), .bus(bus.device), .external_wake_input(wake),
    .downstream_command_channel(cmd), .serial_data_in(sd), .strobe_in(stb),
    .upstream_indication(ind), .highway_clock_enable(hce), .line_active(la),
    .upstream_data_low(udl), .reset_strobe_pin(pin), .serial_data_out_pin(sdo),
    .serial_data_out_oe_n(oe_n), .reference_disable(rdis), .addressing_select(addr_sel),
    .block_reset(blk));
  mrc_checker u_mrc_checker (.clock(clock), .rst(rst), .cs(bus.cs), .wr(bus.wr), .rd(bus.rd),
    .addr(bus.addr), .rdata(bus.rdata), .reset_strobe_pin(pin), .strobe_in(stb),
    .highway_clock_enable(hce), .upstream_indication(ind), .addressing_select(addr_sel),
    .reference_disable(rdis), .upstream_data_low(udl), .block_reset(blk),
    .downstream_command_channel(cmd));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until taken, then waits for the host to go idle again
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    for (int i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clock);
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    for (int i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clock);
    chk(8'(req_ready), 8'h01);
    // One more cycle lets a write's answer pulse pass before a new note is queued
    @(negedge clock);
  endtask : acc
  task automatic get(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask : get
  task automatic settle();
    repeat (4) @(negedge clock);
  endtask : settle
  task automatic cmdset(input logic [3:0] c);
    @(posedge clock);
    cmd <= c;
  endtask : cmdset
  task automatic wake_pulse();
    @(posedge clock);
    wake <= 1'b1;
    @(posedge clock);
    wake <= 1'b0;
  endtask : wake_pulse
  // Counts high cycles of the pin over a window
  task automatic pulse_chk(input int win, input int want);
    int hi;
    hi = 0;
    for (int n = 0; n < win; n++) begin
      @(negedge clock);
      hi += int'(pin === 1'b1);
    end
    chk(8'(hi), 8'(want));
  endtask : pulse_chk
  task automatic wrap_up();
    chk(8'(expq.size()), 8'h00);
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // Processes
  // ----------------------------------------
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (resp_valid === 1'b1 && expq.size() > 0) chk(resp_data, expq.pop_front());
  end
  // Far beyond the roughly one thousand cycles the sequence needs
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    logic [7:0] v;
    void'($urandom(33));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    settle();
    chk(8'(hce), 8'h01);
    get(8'h3e, 8'h00);
    get(8'h3b, {2'b00, dnum});
    get(8'h30, 8'h00);
    cmdset(mrc_pkg::mrc_line_activate_cmd);
    settle();
    chk(8'(la), 8'h01);
    cmdset(mrc_pkg::mrc_clock_up_cmd);
    settle();
    chk(8'(ind), 8'h07);
    cmdset(mrc_pkg::mrc_sleep_notice_cmd);
    settle();
    chk(8'(la), 8'h00);
    chk(8'(ind), 8'h0f);
    chk(8'(hce), 8'h01);
    acc(1'b1, 8'h3d, 8'h08);
    chk(8'(ind), 8'h0f);
    chk(8'(hce), 8'h00);
    acc(1'b1, 8'h56, 8'h80);
    chk(8'(udl), 8'h01);
    chk(8'(hce), 8'h01);
    acc(1'b1, 8'h56, 8'h00);
    cmdset(mrc_pkg::mrc_line_activate_cmd);
    settle();
    chk(8'(la), 8'h01);
    cmdset(mrc_pkg::mrc_sleep_notice_cmd);
    settle();
    chk(8'(ind), 8'h0f);
    acc(1'b1, 8'h3d, 8'h00);
    chk(8'(hce), 8'h01);
    chk(8'(ind), 8'h07);
    v = (8'($urandom()) & 8'hfd) | 8'h01;
    acc(1'b1, 8'h3e, v);
    chk(8'(rdis), 8'(v[2]));
    get(8'h3e, v & 8'h07);
    @(posedge clock);
    sd <= 1'b1;
    settle();
    chk(8'(oe_n), 8'(!v[0]));
    chk(8'(sdo), 8'h01);
    acc(1'b1, 8'h3e, 8'h02);
    chk(8'(oe_n), 8'h01);
    @(posedge clock);
    direct_mode <= 1'b1;
    get(8'h3e, 8'h02);
    acc(1'b1, 8'h3e, 8'h00);
    @(posedge clock);
    direct_mode <= 1'b0;
    v = 8'($urandom());
    acc(1'b1, 8'h3f, v);
    chk(8'(blk), {2'b00, v[5:0]});
    get(8'h3f, 8'h00);
    chk(8'(blk), {2'b00, v[5:0]});
    acc(1'b1, 8'h3f, 8'h00);
    chk(8'(blk), 8'h00);
    acc(1'b1, 8'h3d, 8'h01);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      stb <= 1'($urandom());
      @(negedge clock);
      chk(8'(pin), 8'(stb));
    end
    @(posedge clock);
    stb <= 1'b0;
    acc(1'b1, 8'h3d, 8'h00);
    cmdset(4'h9);
    pulse_chk(60, 0);
    wake_pulse();
    pulse_chk(60, 0);
    acc(1'b1, 8'h3d, 8'h02);
    cmdset(4'h5);
    pulse_chk(60, pulse);
    get(8'h3c, 8'h20);
    get(8'h3c, 8'h00);
    wake_pulse();
    pulse_chk(60, pulse);
    get(8'h3c, 8'h00);
    acc(1'b1, 8'h3d, 8'h03);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 8'h3d, 8'h23);
      acc(1'b1, 8'h3d, 8'h13);
      pulse_chk(100, 0);
    end
    pulse_chk(260, pulse);
    get(8'h3c, 8'h08);
    get(8'h3c, 8'h00);
    acc(1'b1, 8'h3d, 8'h00);
    wrap_up();
  end
endmodule : tb_mode_reset_control
`default_nettype wire

// file: inc/mrc_if.sv
// Parallel register port between host and device
`timescale 1ns/1ps
`default_nettype none
interface mrc_if;
  logic cs;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport device (input cs, input wr, input rd, input addr, input wdata, output rdata);
  modport host (output cs, output wr, output rd, output addr, output wdata, input rdata);
endinterface : mrc_if
`default_nettype wire

// file: inc/mrc_pkg.sv
// Shared constants for the mode and reset control unit
package mrc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] mrc_mode1_off = 8'h3d;
  localparam logic [7:0] mrc_options_off = 8'h3e;
  localparam logic [7:0] mrc_soft_reset_off = 8'h3f;
  localparam logic [7:0] mrc_irq_status_off = 8'h3c;
  localparam logic [7:0] mrc_ident_off = 8'h3b;
  localparam logic [7:0] mrc_highway_ctrl_off = 8'h56;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int mrc_kick1_bit = 5;
  localparam int mrc_kick2_bit = 4;
  localparam int mrc_keepalive_bit = 3;
  localparam int mrc_wdog_flag_bit = 3;
  localparam int mrc_cmd_flag_bit = 5;
  localparam int mrc_wakeup_bit = 7;
  localparam int mrc_refdis_bit = 2;
  localparam int mrc_addr_sel_bit = 1;
  localparam int mrc_drive_bit = 0;
  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] mrc_options_rst = 8'h00;
  localparam logic [7:0] mrc_options_mask = 8'h07;
  localparam logic [7:0] mrc_soft_reset_rst = 8'h00;
  localparam logic [7:0] mrc_soft_reset_mask = 8'h3f;
  // ----------------------------------------
  // Reset source selection and state codes
  // ----------------------------------------
  localparam logic [1:0] mrc_src_none = 2'h0;
  localparam logic [1:0] mrc_src_strobe = 2'h1;
  localparam logic [1:0] mrc_src_event = 2'h2;
  localparam logic [1:0] mrc_src_watchdog = 2'h3;
  localparam logic [3:0] mrc_sleep_state_code = 4'hf;
  localparam logic [3:0] mrc_awake_state_code = 4'h7;
  localparam logic [3:0] mrc_clock_up_cmd = 4'h0;
  localparam logic [3:0] mrc_sleep_notice_cmd = 4'hf;
  localparam logic [3:0] mrc_line_activate_cmd = 4'h8;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int mrc_clk_mhz = 100;
  localparam int mrc_pulse_min_us = 125;
  localparam int mrc_pulse_max_us = 250;
  localparam int mrc_pulse_cycles = (mrc_pulse_min_us + mrc_pulse_max_us) / 2 * mrc_clk_mhz;
  localparam int mrc_wdog_ms = 128;
  localparam int mrc_wdog_cycles = mrc_wdog_ms * 1000 * mrc_clk_mhz;
endpackage : mrc_pkg

// file: src/mrc_device.sv
// Device end: mode, reset source and identification control
//
// How it works
// - Keepalive 0 keeps highway clocks, codes differ
// - Clock-up wakes, sleep-notice sleeps
// - Line-activate accepted without prior clock-up
// - Keepalive 1 stops clocks in sleep; wake bit restores
// - Line-activate then sleep-notice re-enters sleep
// - Reset leaves highway active; host sets keepalive
// - Select 00 gives no event reset
// - Select 01 drives second strobe on pin
// - Select 10: wake or command change pulses
// - Select 11 enables watchdog as source
// - Hardware reset always drives reset pin
// - Command or watchdog pulse raises matching interrupt flag; wake pulse raises none
// - Options register: zeros high, reference disable
// - Addressing select: indirect latch or direct
// - Serial out open drain or push-pull
// - Read-only six-bit design number
// - Soft reset bits hold blocks in reset
// - Host kicks watchdog 1,0 then 0,1
// - Expiry pulses, then sets flag; status read clears
// - Wake bit pulls upstream line low
`timescale 1ns/1ps
`default_nettype none
module mrc_device #(
  parameter logic [5:0] design_number = 6'h2a, // Arbitrary value
  parameter int pulse_cycles = mrc_pkg::mrc_pulse_cycles,
  parameter int wdog_cycles = mrc_pkg::mrc_wdog_cycles
) (
  input wire logic clock,
  input wire logic rst,
  mrc_if.device bus,
  input wire logic external_wake_input,
  input wire logic [3:0] downstream_command_channel,
  input wire logic serial_data_in,
  input wire logic strobe_in,
  output logic [3:0] upstream_indication,
  output logic highway_clock_enable,
  output logic line_active,
  output logic upstream_data_low,
  output logic reset_strobe_pin,
  output logic serial_data_out_pin,
  output logic serial_data_out_oe_n,
  output logic reference_disable,
  output logic addressing_select,
  output logic [5:0] block_reset
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr_latch;
    logic [7:0] mode1;
    logic [7:0] options;
    logic [7:0] soft_reset;
    logic wakeup;
    logic wdog_flag;
    logic cmd_flag;
    logic awake;
    logic active;
    logic [3:0] cmd_prev;
    logic [31:0] pulse_cnt;
    logic [31:0] wdog_cnt;
    logic kick_armed;
    logic pend_cmd;
    logic pend_wdog;
    logic [7:0] rdata;
    logic sdo;
  } mrc_dev_state_t;
  mrc_dev_state_t s_r, s_nxt;
  logic [7:0] eff_addr;
  logic wr_en, rd_en, keepalive;

  always_comb begin
    s_nxt = s_r;
    keepalive = s_r.mode1[mrc_pkg::mrc_keepalive_bit];
    eff_addr = s_r.addr_latch;
    wr_en = 1'b0;
    rd_en = 1'b0;
    // Indirect mode uses A0 as latch/data select
    if (s_r.options[mrc_pkg::mrc_addr_sel_bit]) begin
      eff_addr = bus.addr;
      wr_en = bus.cs & bus.wr;
      rd_en = bus.cs & bus.rd;
    end else if (bus.cs & bus.wr & ~bus.addr[0]) begin
      s_nxt.addr_latch = bus.wdata;
    end else begin
      wr_en = bus.cs & bus.wr & bus.addr[0];
      rd_en = bus.cs & bus.rd & bus.addr[0];
    end
    // Writes
    if (wr_en) begin
      if (eff_addr == mrc_pkg::mrc_mode1_off) begin
        s_nxt.mode1 = bus.wdata;
      end else if (eff_addr == mrc_pkg::mrc_options_off) begin
        s_nxt.options = bus.wdata & mrc_pkg::mrc_options_mask;
      end else if (eff_addr == mrc_pkg::mrc_soft_reset_off) begin
        s_nxt.soft_reset = bus.wdata & mrc_pkg::mrc_soft_reset_mask;
      end else if (eff_addr == mrc_pkg::mrc_highway_ctrl_off) begin
        s_nxt.wakeup = bus.wdata[mrc_pkg::mrc_wakeup_bit];
      end
    end
    // Reads; soft reset reads zero and has no side effect
    s_nxt.rdata = 8'h00;
    if (rd_en) begin
      if (eff_addr == mrc_pkg::mrc_mode1_off) begin
        s_nxt.rdata = s_r.mode1;
      end else if (eff_addr == mrc_pkg::mrc_options_off) begin
        s_nxt.rdata = s_r.options;
      end else if (eff_addr == mrc_pkg::mrc_ident_off) begin
        s_nxt.rdata = {2'h0, design_number};
      end else if (eff_addr == mrc_pkg::mrc_irq_status_off) begin
        s_nxt.rdata[mrc_pkg::mrc_wdog_flag_bit] = s_r.wdog_flag;
        s_nxt.rdata[mrc_pkg::mrc_cmd_flag_bit] = s_r.cmd_flag;
        s_nxt.wdog_flag = 1'b0;
        s_nxt.cmd_flag = 1'b0;
      end
    end
    // Power state from highway commands
    if (downstream_command_channel != s_r.cmd_prev) begin
      if (downstream_command_channel == mrc_pkg::mrc_clock_up_cmd) begin
        s_nxt.awake = 1'b1;
      end else if (downstream_command_channel == mrc_pkg::mrc_line_activate_cmd) begin
        s_nxt.awake = 1'b1;
        s_nxt.active = 1'b1;
      end else if (downstream_command_channel == mrc_pkg::mrc_sleep_notice_cmd) begin
        s_nxt.awake = 1'b0;
        s_nxt.active = 1'b0;
      end
      // Change is recorded now; flag rises once the pulse ends
      if (s_r.mode1[1:0] == mrc_pkg::mrc_src_event) begin
        s_nxt.pend_cmd = 1'b1;
        s_nxt.pulse_cnt = 32'(pulse_cycles);
      end
    end
    s_nxt.cmd_prev = downstream_command_channel;
    // Wake bit, or clearing keepalive again, forces awake; sleep stays legal at 0
    if (s_r.wakeup || (keepalive && !s_nxt.mode1[mrc_pkg::mrc_keepalive_bit])) begin
      s_nxt.awake = 1'b1;
    end
    if (external_wake_input && s_r.mode1[1:0] == mrc_pkg::mrc_src_event) begin
      s_nxt.pulse_cnt = 32'(pulse_cycles);
    end
    // Watchdog: kick sequence 1,0 then 0,1 restarts the window
    if (s_r.mode1[1:0] == mrc_pkg::mrc_src_watchdog) begin
      if (s_r.mode1[mrc_pkg::mrc_kick1_bit] && !s_r.mode1[mrc_pkg::mrc_kick2_bit]) begin
        s_nxt.kick_armed = 1'b1;
      end
      if (s_r.kick_armed && !s_r.mode1[mrc_pkg::mrc_kick1_bit]
          && s_r.mode1[mrc_pkg::mrc_kick2_bit]) begin
        s_nxt.kick_armed = 1'b0;
        s_nxt.wdog_cnt = 32'(wdog_cycles);
      end else if (s_r.wdog_cnt == 32'h0) begin
        s_nxt.wdog_cnt = 32'(wdog_cycles);
        s_nxt.pulse_cnt = 32'(pulse_cycles);
        s_nxt.pend_wdog = 1'b1;
      end else begin
        s_nxt.wdog_cnt = s_r.wdog_cnt - 32'h1;
      end
    end else begin
      s_nxt.wdog_cnt = 32'(wdog_cycles);
      s_nxt.kick_armed = 1'b0;
    end
    // Pulse counter on system clock; flag after the pulse, set beats clear
    if (s_r.pulse_cnt != 32'h0) begin
      s_nxt.pulse_cnt = s_r.pulse_cnt - 32'h1;
      if (s_r.pulse_cnt == 32'h1) begin
        if (s_r.pend_wdog) s_nxt.wdog_flag = 1'b1;
        if (s_r.pend_cmd) s_nxt.cmd_flag = 1'b1;
        s_nxt.pend_wdog = 1'b0;
        s_nxt.pend_cmd = 1'b0;
      end
    end
    // Push-pull drives both levels, open drain only pulls low
    s_nxt.sdo = serial_data_in;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0; // Reset leaves keepalive 0, highway active
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.rdata = s_r.rdata;
  assign upstream_indication = s_r.awake ? mrc_pkg::mrc_awake_state_code
                                         : mrc_pkg::mrc_sleep_state_code;
  assign highway_clock_enable = ~s_r.mode1[mrc_pkg::mrc_keepalive_bit] | s_r.awake;
  assign line_active = s_r.active;
  assign upstream_data_low = s_r.wakeup;
  // Hardware reset always shows; select 00 gives nothing else
  assign reset_strobe_pin = rst | ((s_r.mode1[1:0] == mrc_pkg::mrc_src_strobe) ? strobe_in
                                   : (s_r.pulse_cnt != 32'h0));
  assign serial_data_out_pin = s_r.sdo;
  assign serial_data_out_oe_n = ~(s_r.options[mrc_pkg::mrc_drive_bit] | ~s_r.sdo);
  assign reference_disable = s_r.options[mrc_pkg::mrc_refdis_bit];
  assign addressing_select = s_r.options[mrc_pkg::mrc_addr_sel_bit];
  assign block_reset = s_r.soft_reset[5:0];
endmodule : mrc_device
`default_nettype wire

// file: src/mrc_host.sv
// Host end: drives register accesses on the parallel port
`timescale 1ns/1ps
`default_nettype none
module mrc_host (
  input wire logic clock,
  input wire logic rst,
  mrc_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic direct_mode,
  output logic req_ready,
  output logic resp_valid,
  output logic [7:0] resp_data
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [3:0] {
    mrc_idle = 4'h1, mrc_latch = 4'h2, mrc_access = 4'h4, mrc_resp = 4'h8
  } mrc_hstate_t;
  typedef struct packed {
    mrc_hstate_t st;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] data;
    logic valid;
  } mrc_host_state_t;
  mrc_host_state_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    case (s_r.st)
      mrc_idle: begin
        if (req_valid) begin
          s_nxt.wr = req_write;
          s_nxt.addr = req_addr;
          s_nxt.wdata = req_wdata;
          // Indirect mode: latch address first
          s_nxt.st = direct_mode ? mrc_access : mrc_latch;
        end
      end
      mrc_latch: s_nxt.st = mrc_access;
      mrc_access: s_nxt.st = mrc_resp;
      mrc_resp: begin
        s_nxt.data = bus.rdata;
        s_nxt.valid = 1'b1;
        s_nxt.st = mrc_idle;
      end
      default: s_nxt.st = mrc_idle;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '{st: mrc_idle, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Host must kick the watchdog by writing 1,0 then 0,1 into mode1
  assign bus.cs = (s_r.st == mrc_latch) | (s_r.st == mrc_access);
  assign bus.wr = (s_r.st == mrc_latch) | ((s_r.st == mrc_access) & s_r.wr);
  assign bus.rd = (s_r.st == mrc_access) & ~s_r.wr;
  assign bus.addr = (s_r.st == mrc_latch) ? 8'h00 : (direct_mode ? s_r.addr : 8'h01);
  assign bus.wdata = (s_r.st == mrc_latch) ? s_r.addr : s_r.wdata;
  assign req_ready = (s_r.st == mrc_idle);
  assign resp_valid = s_r.valid;
  assign resp_data = s_r.data;
endmodule : mrc_host
`default_nettype wire
